// ===== hdl/bvs_fault_status.v
// bvs_fault_status.v: bus voltage limit and potential short fault status registers
// assumes an upstream management bus engine giving byte-addressed read/write strobes
`timescale 1ns/1ps
`include "bvs_defs.vh"
module bvs_fault_status (
    // clock and reset
    input wire SYS_CLK,
    input wire RESET,
    // register access from the management bus engine
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire WRITE_PROTECT,
    output reg [7:0] REG_RDATA,
    output reg REG_HIT,
    // conversion direction: 1 step-up, 0 step-down
    input wire STEP_UP,
    // comparator levels
    input wire LOW_VOLTAGE_BUS_OV,
    input wire LOW_VOLTAGE_BUS_UV,
    input wire HIGH_VOLTAGE_BUS_OV,
    input wire HIGH_VOLTAGE_BUS_UV,
    // short detectors
    input wire HS_SWITCH_SHORT,
    input wire LOW_VOLTAGE_BUS_GND_SHORT,
    input wire LS_SWITCH_SHORT,
    input wire HIGH_VOLTAGE_BUS_GND_SHORT,
    input wire FLYBACK_SWITCH_SHORT,
    // flag state
    output reg [7:0] BUS_VOLT_FLAGS,
    output reg [7:0] SHORT_FLAGS
);
    wire step_down = ~STEP_UP;
    wire [7:0] bv_set;
    wire [7:0] sh_set;
    wire [7:0] bv_q;
    wire [7:0] sh_q;
    // write protection blocks host writes but never fault capture
    wire wr_ok = REG_WR & ~WRITE_PROTECT;
    wire bv_wr = wr_ok & (REG_ADDR == `BVS_ADDR_BUS_VOLT);
    wire sh_wr = wr_ok & (REG_ADDR == `BVS_ADDR_SHORT);

    assign bv_set[`BVS_BIT_LV_OUT_OV] = step_down & LOW_VOLTAGE_BUS_OV;
    assign bv_set[`BVS_BIT_LV_OUT_UV] = step_down & LOW_VOLTAGE_BUS_UV;
    assign bv_set[`BVS_BIT_LV_IN_OV] = STEP_UP & LOW_VOLTAGE_BUS_OV;
    assign bv_set[`BVS_BIT_LV_IN_UV] = STEP_UP & LOW_VOLTAGE_BUS_UV;
    assign bv_set[`BVS_BIT_HV_OUT_OV] = STEP_UP & HIGH_VOLTAGE_BUS_OV;
    assign bv_set[`BVS_BIT_HV_OUT_UV] = STEP_UP & HIGH_VOLTAGE_BUS_UV;
    assign bv_set[`BVS_BIT_HV_IN_OV] = step_down & HIGH_VOLTAGE_BUS_OV;
    assign bv_set[`BVS_BIT_HV_IN_UV] = step_down & HIGH_VOLTAGE_BUS_UV;

    assign sh_set[`BVS_BIT_HS_SHORT] = HS_SWITCH_SHORT;
    assign sh_set[`BVS_BIT_LV_GND] = LOW_VOLTAGE_BUS_GND_SHORT;
    assign sh_set[`BVS_BIT_LS_SHORT] = LS_SWITCH_SHORT;
    assign sh_set[`BVS_BIT_HV_GND] = HIGH_VOLTAGE_BUS_GND_SHORT;
    assign sh_set[`BVS_BIT_FLY_SHORT] = FLYBACK_SWITCH_SHORT;
    assign sh_set[7:5] = 3'h0;

    bvs_flag_reg #(
        .RESET_VAL(`BVS_RST_BUS_VOLT),
        .IMPL_MASK(8'hff)
    ) u_bus_volt (
        .clk(SYS_CLK),
        .rst(RESET),
        .wr_en(bv_wr),
        .wr_data(REG_WDATA),
        .set(bv_set),
        .flags_q(bv_q)
    );

    bvs_flag_reg #(
        .RESET_VAL(`BVS_RST_SHORT),
        .IMPL_MASK(`BVS_SHORT_MASK)
    ) u_short (
        .clk(SYS_CLK),
        .rst(RESET),
        .wr_en(sh_wr),
        .wr_data(REG_WDATA),
        .set(sh_set),
        .flags_q(sh_q)
    );

    // read data registered one cycle after REG_RD; unmapped reads give zero, no hit
    always @(posedge SYS_CLK) begin
        if (RESET) begin
            REG_RDATA <= 8'h00;
            REG_HIT <= 1'b0;
            BUS_VOLT_FLAGS <= 8'h00;
            SHORT_FLAGS <= 8'h00;
        end else begin
            BUS_VOLT_FLAGS <= bv_q;
            SHORT_FLAGS <= sh_q;
            REG_RDATA <= 8'h00;
            REG_HIT <= 1'b0;
            if (REG_RD) begin
                if (REG_ADDR == `BVS_ADDR_BUS_VOLT) begin
                    REG_RDATA <= bv_q;
                    REG_HIT <= 1'b1;
                end else if (REG_ADDR == `BVS_ADDR_SHORT) begin
                    REG_RDATA <= sh_q & `BVS_SHORT_MASK;
                    REG_HIT <= 1'b1;
                end
            end
        end
    end
endmodule // bvs_fault_status

// ===== hdl/bvs_defs.vh
// bvs_defs.vh: offsets, bit positions and reset values of the bus voltage and short fault registers
// assumes inclusion by bare name from the design files under hdl/
// Functional notes
// - bit 0 of bus voltage register sets on low-voltage bus output overvoltage, step-down.
// - bit 1 sets on low-voltage bus output undervoltage during step-down.
// - bit 2 sets on low-voltage bus input overvoltage during step-up.
// - bit 3 sets on low-voltage bus input undervoltage during step-up.
// - bit 4 sets on high-voltage bus output overvoltage during step-up.
// - bit 5 sets on high-voltage bus output undervoltage during step-up.
// - bit 6 sets on high-voltage bus input overvoltage during step-down.
// - bit 7 sets on high-voltage bus input undervoltage during step-down.
// - both registers are one byte, read/write except short bits 7:5 which stay zero, all zeros after reset.
// - short register bits: high-side, low bus ground, low-side, high bus ground, flyback.
`ifndef BVS_DEFS_VH
`define BVS_DEFS_VH
`define BVS_ADDR_BUS_VOLT 8'hd7
`define BVS_ADDR_SHORT 8'hd8
`define BVS_RST_BUS_VOLT 8'h00
`define BVS_RST_SHORT 8'h00
`define BVS_SHORT_MASK 8'h1f
`define BVS_BIT_LV_OUT_OV 0
`define BVS_BIT_LV_OUT_UV 1
`define BVS_BIT_LV_IN_OV 2
`define BVS_BIT_LV_IN_UV 3
`define BVS_BIT_HV_OUT_OV 4
`define BVS_BIT_HV_OUT_UV 5
`define BVS_BIT_HV_IN_OV 6
`define BVS_BIT_HV_IN_UV 7
`define BVS_BIT_HS_SHORT 0
`define BVS_BIT_LV_GND 1
`define BVS_BIT_LS_SHORT 2
`define BVS_BIT_HV_GND 3
`define BVS_BIT_FLY_SHORT 4
`endif

// ===== hdl/bvs_flag_reg.v
// bvs_flag_reg.v: one byte of sticky fault flags with host overwrite
// assumes set inputs and write strobe synchronous to clk
`timescale 1ns/1ps
module bvs_flag_reg #(
    parameter [7:0] RESET_VAL = 8'h00,
    parameter [7:0] IMPL_MASK = 8'hff
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // host write
    input wire wr_en,
    input wire [7:0] wr_data,
    // fault events
    input wire [7:0] set,
    // state
    output reg [7:0] flags_q
);
    reg [7:0] flags_d;

    // set wins over a write in the same cycle so no fault is lost
    always @* begin
        flags_d = flags_q;
        if (wr_en) begin
            flags_d = wr_data;
        end
        flags_d = (flags_d | set) & IMPL_MASK;
    end

    always @(posedge clk) begin
        if (rst) begin
            flags_q <= RESET_VAL & IMPL_MASK;
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule // bvs_flag_reg

// ===== tb/bvs_fault_status_assertions.sv
// port checks of the fault registers; assumes a bind onto bvs_fault_status
`timescale 1ns/1ps
module bvs_chk (
    // watched ports
    input wire SYS_CLK, RESET, REG_WR, REG_RD, WRITE_PROTECT, REG_HIT, STEP_UP,
    input wire LOW_VOLTAGE_BUS_UV, HIGH_VOLTAGE_BUS_UV, HS_SWITCH_SHORT,
    input wire [7:0] REG_ADDR, REG_RDATA, BUS_VOLT_FLAGS, SHORT_FLAGS
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    a_rd_volt: assert property (REG_RD && REG_ADDR == 8'hd7 |=> REG_RDATA == BUS_VOLT_FLAGS)
        else $error("voltage read");
    a_rd_short: assert property (REG_RD && REG_ADDR == 8'hd8 |=> REG_RDATA == SHORT_FLAGS)
        else $error("short read");
    a_rd_quiet: assert property (!REG_RD |=> !REG_HIT && REG_RDATA == 8'h00) else $error("idle");
    a_rsv_zero: assert property (SHORT_FLAGS[7:5] == 3'h0) else $error("reserved");
    a_lv_in_uv: assert property (STEP_UP && LOW_VOLTAGE_BUS_UV |-> ##2 BUS_VOLT_FLAGS[3])
        else $error("low bus");
    a_hv_in_uv: assert property (!STEP_UP && HIGH_VOLTAGE_BUS_UV |-> ##2 BUS_VOLT_FLAGS[7])
        else $error("high bus");
    a_hs_short: assert property (HS_SWITCH_SHORT |-> ##2 SHORT_FLAGS[0]) else $error("short");
    a_flag_sticky: assert property ($fell(BUS_VOLT_FLAGS[7]) |-> $past(REG_WR, 2) &&
        !$past(WRITE_PROTECT, 2)) else $error("flag lost");
endmodule // bvs_chk
bind bvs_fault_status bvs_chk u_chk (.*);

// ===== tb/bvs_host.sv
// controller model; assumes strobes are sampled on the rising edge
`timescale 1ns/1ps
module bvs_host (
    // register strobes
    input wire SYS_CLK,
    output reg REG_WR = 1'b0, REG_RD = 1'b0,
    output reg [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00
);
    // released lines invert so a stale value cannot pass
    task xfer(input reg w, input reg [7:0] a, input reg [7:0] d);
        @(posedge SYS_CLK) #1 {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {w, !w, a, d};
        @(posedge SYS_CLK) #1 {REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {2'b00, ~a, ~d};
    endtask
endmodule // bvs_host

// ===== tb/tb.sv
// self-checking bench; assumes bvs_host issues all register strobes
`timescale 1ns/1ps
module tb;
    reg SYS_CLK = 1'b0, RESET = 1'b1, WRITE_PROTECT = 1'b0, STEP_UP = 1'b0;
    reg [8:0] f = 9'h000;
    wire REG_WR, REG_RD, REG_HIT;
    wire [7:0] REG_ADDR, REG_WDATA, REG_RDATA, BUS_VOLT_FLAGS, SHORT_FLAGS;
    integer bad_count = 0, checks_done = 0, i;
    bvs_host h (.*);
    bvs_fault_status DUT (.*, .LOW_VOLTAGE_BUS_OV(f[0]), .LOW_VOLTAGE_BUS_UV(f[1]),
        .HIGH_VOLTAGE_BUS_OV(f[2]), .HIGH_VOLTAGE_BUS_UV(f[3]), .HS_SWITCH_SHORT(f[4]),
        .LOW_VOLTAGE_BUS_GND_SHORT(f[5]), .LS_SWITCH_SHORT(f[6]),
        .HIGH_VOLTAGE_BUS_GND_SHORT(f[7]), .FLYBACK_SWITCH_SHORT(f[8]));
    initial forever #4 SYS_CLK = ~SYS_CLK;
    task test_done;
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one-cycle fault pulse, so a set bit proves the flag latched
    task ck(input reg [8:0] p, input reg [7:0] a, input reg [7:0] e);
        @(posedge SYS_CLK) #1 f = p;
        @(posedge SYS_CLK) #1 f = 9'h000;
        h.xfer(1'b0, a, 8'h00);
        checks_done = checks_done + 1;
        if (REG_RDATA !== e || REG_HIT !== (a == 8'hd7 || a == 8'hd8)) begin
            bad_count = bad_count + 1;
            $display("unexpected %0t %h %h", $time, REG_RDATA, e);
        end
    endtask
    task t_volt;
        ck(9'h000, 8'hd7, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            STEP_UP = i[2];
            ck(9'h001 << i[1:0], 8'hd7, 8'h01 << (i[2] ? i - 2 : i + i[1] * 4));
            h.xfer(1'b1, 8'hd7, 8'h00);
        end
        WRITE_PROTECT = 1'b1;
        ck(9'h008, 8'hd7, 8'h20);
        h.xfer(1'b1, 8'hd7, 8'h00);
        ck(9'h000, 8'hd7, 8'h20);
        WRITE_PROTECT = 1'b0;
        h.xfer(1'b1, 8'hd7, 8'h5a);
        ck(9'h000, 8'hd7, 8'h5a);
    endtask
    task t_short;
        for (i = 0; i < 5; i = i + 1) begin
            ck(9'h010 << i, 8'hd8, 8'h01 << i);
            h.xfer(1'b1, 8'hd8, 8'h00);
        end
        h.xfer(1'b1, 8'hd8, 8'hff);
        ck(9'h000, 8'hd8, 8'h1f);
        ck(9'h000, 8'hd9, 8'h00);
    endtask
    initial begin
        repeat (5) @(posedge SYS_CLK);
        #1 RESET = 1'b0;
        t_volt;
        t_short;
        test_done;
    end
    initial begin
        #20000 bad_count = bad_count + 1;
        test_done;
    end
endmodule // tb
